// ===== pkg/anpr_pkg.sv
package anpr_pkg;

  // Management device and frame layout
  localparam logic [4:0]  MMD_ADDR   = 5'h07;
  localparam logic [1:0]  OP_ADDR    = 2'h0;
  localparam logic [1:0]  OP_WRITE   = 2'h1;
  localparam logic [1:0]  OP_RINC    = 2'h2;
  localparam logic [5:0]  PRE_ONES   = 6'h20;
  localparam logic [4:0]  HDR_LAST   = 5'h0b;
  localparam logic [4:0]  TA_LAST    = 5'h01;
  localparam logic [4:0]  DATA_LAST  = 5'h0f;

  // Register offsets
  localparam logic [15:0] OFS_LP0    = 16'h0013;
  localparam logic [15:0] OFS_LP1    = 16'h0014;
  localparam logic [15:0] OFS_LP2    = 16'h0015;
  localparam logic [15:0] OFS_NP0    = 16'h0016;
  localparam logic [15:0] OFS_NP1    = 16'h0017;
  localparam logic [15:0] OFS_NP2    = 16'h0018;

  // Reset values
  localparam logic [15:0] RST_LP0    = 16'h0001;
  localparam logic [15:0] RST_LP1    = 16'h0000;
  localparam logic [15:0] RST_LP2    = 16'h0000;
  localparam logic [15:0] RST_NP0    = 16'h2000;
  localparam logic [15:0] RST_NP1    = 16'h0000;
  localparam logic [15:0] RST_NP2    = 16'h0000;

  // Field positions
  localparam int          MORE_POS   = 15;
  localparam int          ACK_POS    = 14;
  localparam int          MSG_POS    = 13;
  localparam int          ACT_POS    = 12;
  localparam int          TOG_POS    = 11;
  localparam int          CODE_MSB   = 10;
  localparam int          SEL_MSB    = 4;
  localparam logic [4:0]  SELECTOR   = 5'h01;

  typedef struct packed {
    logic [15:0] w2;
    logic [15:0] w1;
    logic [15:0] w0;
  } anpr_page_type;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_HDR,
    ST_TA,
    ST_DATA
  } anpr_state_type;

endpackage

// ===== rtl/anpr_partner_capture.sv
`timescale 1ns/10ps
module anpr_partner_capture
  import anpr_pkg::*;
(
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          resetn,
  // Received page
  input  wire anpr_page_type rx_page,
  input  wire logic          rx_page_valid,
  // Word 0 read taken
  input  wire logic          snap,
  // Read views
  output logic [15:0]        lp_w0,
  output logic [15:0]        lp_w1,
  output logic [15:0]        lp_w2
);

  anpr_page_type live_q;
  anpr_page_type shd_q;

  // Whole page lands in one edge so no word mixes two pages
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      live_q <= '{w2: RST_LP2, w1: RST_LP1, w0: RST_LP0};
    else if (rx_page_valid)
      live_q <= '{w2: rx_page.w2, w1: rx_page.w1,
                  w0: {rx_page.w0[15:SEL_MSB+1], SELECTOR}}; // R21
  end

  // Words 1 and 2 freeze when word 0 is read
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      shd_q <= '{w2: RST_LP2, w1: RST_LP1, w0: RST_LP0};
    else if (snap)
      shd_q <= live_q; // R7
  end

  assign lp_w0 = live_q.w0;
  assign lp_w1 = shd_q.w1;
  assign lp_w2 = shd_q.w2;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_selector_const: assert property ( // R6
    live_q.w0[SEL_MSB:0] == SELECTOR)
    else $error("selector field not constant");

  a_capture_all: assert property ( // R1 R2 R3 R4 R5 R8 R9 R10 R11 R12 R13 R21
    rx_page_valid |=> live_q.w0[15:5] == $past(rx_page.w0[15:5])
      && live_q.w1 == $past(rx_page.w1) && live_q.w2 == $past(rx_page.w2))
    else $error("partner page not captured whole");

  a_snap_coherent: assert property ( // R7
    snap ##1 !snap[*2] |-> lp_w1 == $past(live_q.w1, 2)
      && lp_w2 == $past(live_q.w2, 2))
    else $error("frozen words differ from page at word 0 read");

endmodule // anpr_partner_capture

// ===== rtl/anpr_toggle_gen.sv
`timescale 1ns/10ps
module anpr_toggle_gen
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic resetn,
  // Sequencing events
  input  wire logic an_restart,
  input  wire logic base_toggle,
  input  wire logic np_sent,
  // Toggle for the next page
  output logic      toggle
);

  logic toggle_q;

  // First next page carries the inverse of the base page toggle
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      toggle_q <= 1'b0;
    else if (an_restart)
      toggle_q <= ~base_toggle; // R17
    else if (np_sent)
      toggle_q <= ~toggle_q; // R17
  end

  assign toggle = toggle_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_toggle_flip: assert property ( // R17
    np_sent && !an_restart |=> toggle_q != $past(toggle_q))
    else $error("toggle did not flip after page sent");

endmodule // anpr_toggle_gen

// ===== rtl/anpr_page_regs.sv
`timescale 1ns/10ps
// Behaviour
// R1 - Word0 bit15 shows partner next page flag
// R2 - Word0 bit14 shows partner acknowledge, read-only
// R3 - Word0 bit13 shows partner remote fault
// R4 - Word0 bits12:10 show partner pause capabilities
// R5 - Word0 bits9:5 show partner echoed nonce
// R6 - Word0 bits4:0 always read 00001
// R7 - Host reads word0 before words 1, 2
// R8 - Word1 bits15:8 show partner ability 10:3
// R9 - Word1 bit7 shows partner KR ability
// R10 - Word1 bits6,5 show ability 1, KX ability
// R11 - Word1 bits4:0 show partner sent nonce
// R12 - Word2 bits15,14 show partner FEC request, ability
// R13 - Word2 bits13:0 show partner ability 24:11
// R14 - Local bit15 sets sent next page flag
// R15 - Local bit13 selects message page, resets one
// R16 - Local bit12 drives can-act bit, resets zero
// R17 - Hardware makes toggle; bit11 only stored
// R18 - Local bits10:0 drive code field D10:D0
// R19 - Local word1 drives sent bits D31:D16
// R20 - Local word2 drives sent bits D47:D32
// R21 - Partner page captured as one unit
module anpr_page_regs
  import anpr_pkg::*;
(
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          resetn,
  // Management serial pins
  input  wire logic          mdc,
  input  wire logic          mdio_in,
  output logic               mdio_out,
  output logic               mdio_oe,
  input  wire logic [4:0]    port_addr,
  // Partner page from the receiver
  input  wire anpr_page_type rx_page,
  input  wire logic          rx_page_valid,
  // Next page sequencing
  input  wire logic          an_restart,
  input  wire logic          base_toggle,
  input  wire logic          np_sent,
  // Next page toward the transmitter
  output anpr_page_type      tx_page
);

  anpr_state_type state_q;
  logic           mdc_q;
  logic [5:0]     ones_q;
  logic [4:0]     cnt_q;
  logic [11:0]    hdr_q;
  logic [15:0]    addr_q;
  logic [15:0]    shift_q;
  logic           local_more_pages_flag_q;
  logic           local_message_page_select_q;
  logic           local_can_act_flag_q;
  logic           local_toggle_shadow_q;
  logic [10:0]    local_page_code_low_q;
  logic [15:0]    local_page_code_mid_q;
  logic [15:0]    local_page_code_top_q;
  logic [15:0]    lp_w0;
  logic [15:0]    lp_w1;
  logic [15:0]    lp_w2;
  logic [15:0]    np0_word;
  logic [15:0]    wdata;
  logic           toggle;
  logic           mdc_rise;
  logic           frame_hit;
  logic           is_read;
  logic           rd_load;
  logic           ta_end;
  logic           data_end;
  logic           reg_wr;
  logic           snap;

  // Pins are already in the mclk domain, so a delayed copy finds edges
  assign mdc_rise  = mdc & ~mdc_q;
  assign frame_hit = (hdr_q[9:5] == port_addr) && (hdr_q[4:0] == MMD_ADDR);
  assign is_read   = hdr_q[11];
  assign rd_load   = mdc_rise && (state_q == ST_TA) && (cnt_q == 5'h00)
                     && frame_hit && is_read;
  assign ta_end    = mdc_rise && (state_q == ST_TA) && (cnt_q == TA_LAST);
  assign data_end  = mdc_rise && (state_q == ST_DATA) && (cnt_q == DATA_LAST);
  assign wdata     = {shift_q[14:0], mdio_in};
  assign reg_wr    = data_end && frame_hit && (hdr_q[11:10] == OP_WRITE);
  assign snap      = rd_load && (addr_q == OFS_LP0); // R7

  // Reserved bit reads zero; the stored toggle is only echoed back
  assign np0_word  = {local_more_pages_flag_q, 1'b0,
                      local_message_page_select_q, local_can_act_flag_q,
                      local_toggle_shadow_q, local_page_code_low_q};

  function automatic logic [15:0] read_word(input logic [15:0] a);
    if (a == OFS_LP0)
      read_word = lp_w0; // R1 R2 R3 R4 R5 R6
    else if (a == OFS_LP1)
      read_word = lp_w1; // R8 R9 R10 R11
    else if (a == OFS_LP2)
      read_word = lp_w2; // R12 R13
    else if (a == OFS_NP0)
      read_word = np0_word;
    else if (a == OFS_NP1)
      read_word = local_page_code_mid_q;
    else if (a == OFS_NP2)
      read_word = local_page_code_top_q;
    else
      read_word = 16'h0000;
  endfunction

  anpr_partner_capture u_capture (
    .mclk          (mclk),
    .resetn        (resetn),
    .rx_page       (rx_page),
    .rx_page_valid (rx_page_valid),
    .snap          (snap),
    .lp_w0         (lp_w0),
    .lp_w1         (lp_w1),
    .lp_w2         (lp_w2)
  );

  anpr_toggle_gen u_toggle (
    .mclk        (mclk),
    .resetn      (resetn),
    .an_restart  (an_restart),
    .base_toggle (base_toggle),
    .np_sent     (np_sent),
    .toggle      (toggle)
  );

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      mdc_q <= 1'b0;
    else
      mdc_q <= mdc;
  end

  // Frame sequencer; each frame needs a full preamble, none suppressed
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= ST_IDLE;
      ones_q  <= 6'h00;
      cnt_q   <= 5'h00;
      hdr_q   <= 12'h000;
    end
    else if (mdc_rise)
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (mdio_in)
          begin
            if (ones_q != PRE_ONES)
              ones_q <= ones_q + 6'h01;
          end
          else
          begin
            if (ones_q == PRE_ONES)
              state_q <= ST_START;
            ones_q <= 6'h00;
          end
        end
        ST_START:
        begin
          cnt_q   <= 5'h00;
          state_q <= mdio_in ? ST_IDLE : ST_HDR;
        end
        ST_HDR:
        begin
          hdr_q <= {hdr_q[10:0], mdio_in};
          if (cnt_q == HDR_LAST)
          begin
            cnt_q   <= 5'h00;
            state_q <= ST_TA;
          end
          else
            cnt_q <= cnt_q + 5'h01;
        end
        ST_TA:
        begin
          if (cnt_q == TA_LAST)
          begin
            cnt_q   <= 5'h00;
            state_q <= ST_DATA;
          end
          else
            cnt_q <= cnt_q + 5'h01;
        end
        ST_DATA:
        begin
          if (cnt_q == DATA_LAST)
          begin
            cnt_q   <= 5'h00;
            state_q <= ST_IDLE;
          end
          else
            cnt_q <= cnt_q + 5'h01;
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // Data shifter serves both directions
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      shift_q <= 16'h0000;
    else if (rd_load)
      shift_q <= read_word(addr_q);
    else if (mdc_rise && (state_q == ST_DATA))
      shift_q <= wdata;
  end

  // Pin driver: zero in second turnaround bit, then data MSB first
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      mdio_oe  <= 1'b0;
      mdio_out <= 1'b1;
    end
    else if (rd_load)
    begin
      mdio_oe  <= 1'b1;
      mdio_out <= 1'b0;
    end
    else if (data_end)
    begin
      mdio_oe  <= 1'b0;
      mdio_out <= 1'b1;
    end
    else if (mdio_oe && ta_end)
      mdio_out <= shift_q[15];
    else if (mdio_oe && mdc_rise && (state_q == ST_DATA))
      mdio_out <= shift_q[14];
  end

  // Address register; read-increment steps after the data phase
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      addr_q <= 16'h0000;
    else if (data_end && frame_hit)
    begin
      if (hdr_q[11:10] == OP_ADDR)
        addr_q <= wdata;
      else if (hdr_q[11:10] == OP_RINC)
        addr_q <= addr_q + 16'h0001;
    end
  end

  // Local next page storage
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      local_more_pages_flag_q     <= RST_NP0[MORE_POS];
      local_message_page_select_q <= RST_NP0[MSG_POS];
      local_can_act_flag_q        <= RST_NP0[ACT_POS];
      local_toggle_shadow_q       <= RST_NP0[TOG_POS];
      local_page_code_low_q       <= RST_NP0[CODE_MSB:0];
      local_page_code_mid_q       <= RST_NP1;
      local_page_code_top_q       <= RST_NP2;
    end
    else if (reg_wr)
    begin
      if (addr_q == OFS_NP0)
      begin
        local_more_pages_flag_q     <= wdata[MORE_POS]; // R14
        local_message_page_select_q <= wdata[MSG_POS]; // R15
        local_can_act_flag_q        <= wdata[ACT_POS]; // R16
        local_toggle_shadow_q       <= wdata[TOG_POS]; // R17
        local_page_code_low_q       <= wdata[CODE_MSB:0]; // R18
      end
      else if (addr_q == OFS_NP1)
        local_page_code_mid_q <= wdata; // R19
      else if (addr_q == OFS_NP2)
        local_page_code_top_q <= wdata; // R20
    end
  end

  // Page for the transmitter; acknowledge belongs to the arbitration engine
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      tx_page <= '{w2: RST_NP2, w1: RST_NP1, w0: RST_NP0};
    else
    begin
      tx_page.w0 <= {local_more_pages_flag_q, 1'b0, // R14
                     local_message_page_select_q, // R15
                     local_can_act_flag_q, // R16
                     toggle, // R17
                     local_page_code_low_q}; // R18
      tx_page.w1 <= local_page_code_mid_q; // R19
      tx_page.w2 <= local_page_code_top_q; // R20
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_tx_flags: assert property ( // R14 R15 R16
    tx_page.w0[15:12] == {$past(local_more_pages_flag_q), 1'b0,
                          $past(local_message_page_select_q),
                          $past(local_can_act_flag_q)})
    else $error("next page flag bits wrong");

  a_tx_toggle: assert property ( // R17
    tx_page.w0[TOG_POS] == $past(toggle))
    else $error("sent toggle not from hardware");

  a_tx_code: assert property ( // R18
    tx_page.w0[CODE_MSB:0] == $past(local_page_code_low_q))
    else $error("code field not sent");

  a_tx_upper: assert property ( // R19 R20
    tx_page.w1 == $past(local_page_code_mid_q)
      && tx_page.w2 == $past(local_page_code_top_q))
    else $error("upper next page words not sent");

  a_np_write: assert property ( // R14 R15 R16 R17 R18
    reg_wr && addr_q == OFS_NP0 |=> np0_word == ($past(wdata) & 16'hbfff))
    else $error("local word 0 write not stored");

  a_write_reaches_tx: assert property ( // R19
    reg_wr && addr_q == OFS_NP1 ##1 !reg_wr |=> tx_page.w1 == $past(wdata, 2))
    else $error("local word 1 write not sent");

  a_sel_read: assert property ( // R6
    rd_load && addr_q == OFS_LP0 |=> shift_q[SEL_MSB:0] == SELECTOR)
    else $error("selector read not constant");

  a_read_turn: assert property ( // R7
    rd_load |=> mdio_oe && !mdio_out)
    else $error("turnaround zero not driven");

  c_write_np0: cover property (reg_wr && addr_q == OFS_NP0);
  c_read_lp0:  cover property (snap ##[1:400] rd_load && addr_q == OFS_LP1);
  c_capture:   cover property (rx_page_valid ##[1:700] snap);

endmodule // anpr_page_regs

// ===== test/anpr_mdio_host.sv
`timescale 1ns/10ps
module anpr_mdio_host
  import anpr_pkg::*;
(
  // Clock
  input  wire logic mclk,
  // Management pins
  input  wire logic mdio_w,
  output logic      mdc,
  output logic      h_oe,
  output logic      h_val
);
  // Clock stands low and the line is released between frames
  initial
  begin
    mdc   = 1'b0;
    h_oe  = 1'b0;
    h_val = 1'b1;
  end

  // One frame, MSB first; rdat holds the second turnaround bit, then the data
  task automatic frame(input int npre, input logic [1:0] op, input logic [4:0] prt,
                       input logic [4:0] dev, input logic [15:0] data,
                       output logic [16:0] rdat);
    logic [31:0] body;
    int          k;
    body = {2'b00, op, prt, dev, 2'b10, data};
    rdat = 17'h00000;
    for (int j = 0; j < npre + 32; j++)
    begin
      k = j - npre;
      @(negedge mclk);
      mdc   <= 1'b0;
      h_oe  <= !(op[1] && k >= 14);
      h_val <= (k < 0) ? 1'b1 : body[31 - k];
      repeat (2) @(negedge mclk);
      // Sampled just before our own rise, three and a half mclk cycles after the device changed it
      if (k >= 15)
        rdat = {rdat[15:0], mdio_w};
      mdc <= 1'b1;
      @(negedge mclk);
    end
    @(negedge mclk);
    mdc   <= 1'b0;
    h_oe  <= 1'b0;
    h_val <= 1'b1;
    // Lets the write land in the register and then in the transmit page
    repeat (3) @(negedge mclk);
  endtask
endmodule // anpr_mdio_host

// ===== test/tb_anpr_page_regs.sv
`timescale 1ns/10ps
module tb_anpr_page_regs
  import anpr_pkg::*;
;
  logic          mclk;
  logic          resetn;
  logic          mdc;
  logic          h_oe;
  logic          h_val;
  logic          mdio_out;
  logic          mdio_oe;
  logic [4:0]    port_addr;
  anpr_page_type rx_page;
  logic          rx_page_valid;
  logic          an_restart;
  logic          base_toggle;
  logic          np_sent;
  anpr_page_type tx_page;
  wire logic     mdio_w;
  logic [16:0]   r;
  int            bad_count;
  int            n_tests;

  // Line has a pull-up, so a released wire reads one
  assign mdio_w = mdio_oe ? mdio_out : (h_oe ? h_val : 1'b1);

  anpr_mdio_host host (
    .mclk   (mclk),
    .mdio_w (mdio_w),
    .mdc    (mdc),
    .h_oe   (h_oe),
    .h_val  (h_val)
  );

  anpr_page_regs dut (
    .mclk          (mclk),
    .resetn        (resetn),
    .mdc           (mdc),
    .mdio_in       (mdio_w),
    .mdio_out      (mdio_out),
    .mdio_oe       (mdio_oe),
    .port_addr     (port_addr),
    .rx_page       (rx_page),
    .rx_page_valid (rx_page_valid),
    .an_restart    (an_restart),
    .base_toggle   (base_toggle),
    .np_sent       (np_sent),
    .tx_page       (tx_page)
  );

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    host.frame(32, OP_ADDR, port_addr, MMD_ADDR, a, r);
    host.frame(32, OP_WRITE, port_addr, MMD_ADDR, d, r);
  endtask

  // Turnaround bit must be driven low and the drive gone once the frame ends
  task automatic rdn(input logic [1:0] op, input logic [15:0] exp);
    host.frame(32, op, port_addr, MMD_ADDR, 16'h0000, r);
    check(r[15:0], exp);
    check({15'h0000, r[16] | mdio_oe}, 16'h0000);
  endtask

  task automatic rdc(input logic [15:0] a, input logic [15:0] exp);
    host.frame(32, OP_ADDR, port_addr, MMD_ADDR, a, r);
    rdn(2'h3, exp);
  endtask

  task automatic pulse(ref logic s);
    @(negedge mclk);
    s = 1'b1;
    @(negedge mclk);
    s = 1'b0;
    repeat (2) @(negedge mclk);
  endtask

  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Whole run is about 14k cycles of frames
  initial
  begin
    repeat (30000) @(posedge mclk);
    bad_count++;
    $display("[FAIL] %0t ns: watchdog expired", $time);
    end_of_test();
  end

  initial
  begin
    resetn        = 1'b0;
    rx_page       = '0;
    rx_page_valid = 1'b0;
    an_restart    = 1'b0;
    base_toggle   = 1'b0;
    np_sent       = 1'b0;
    port_addr     = 5'h05;
    bad_count     = 0;
    n_tests       = 0;
    repeat (10) @(negedge mclk);
    resetn = 1'b1;
    @(negedge mclk);
    check(tx_page.w0, 16'h2000);
    rdc(OFS_LP0, 16'h0001);
    rdc(OFS_LP1, 16'h0000);
    rdc(OFS_LP2, 16'h0000);
    rdc(OFS_NP0, 16'h2000);
    rdc(OFS_NP1, 16'h0000);
    rdc(OFS_NP2, 16'h0000);
    $display("Test reset values done");

    wr(OFS_NP0, 16'hffff);
    rdc(OFS_NP0, 16'hbfff);
    check(tx_page.w0, 16'hb7ff);
    wr(OFS_NP0, 16'h0800);
    rdc(OFS_NP0, 16'h0800);
    check(tx_page.w0, 16'h0000);
    wr(OFS_NP1, 16'ha5c3);
    wr(OFS_NP2, 16'h3c5a);
    rdc(OFS_NP1, 16'ha5c3);
    rdc(OFS_NP2, 16'h3c5a);
    check(tx_page.w1, 16'ha5c3);
    check(tx_page.w2, 16'h3c5a);
    $display("Test local page done");

    pulse(an_restart);
    check(tx_page.w0, 16'h0800);
    wr(OFS_NP0, 16'h0000);
    check(tx_page.w0, 16'h0800);
    pulse(np_sent);
    check(tx_page.w0, 16'h0000);
    // Restart and page sent together: restart must win and load the inverse
    base_toggle = 1'b1;
    @(negedge mclk);
    an_restart = 1'b1;
    np_sent    = 1'b1;
    @(negedge mclk);
    an_restart = 1'b0;
    np_sent    = 1'b0;
    repeat (2) @(negedge mclk);
    check(tx_page.w0, 16'h0000);
    base_toggle = 1'b0;
    pulse(an_restart);
    check(tx_page.w0, 16'h0800);
    $display("Test toggle done");

    rx_page = {16'hc123, 16'hb7e4, 16'hffff};
    pulse(rx_page_valid);
    host.frame(32, OP_ADDR, port_addr, MMD_ADDR, OFS_LP0, r);
    rdn(OP_RINC, 16'hffe1);
    rdn(OP_RINC, 16'hb7e4);
    rdn(OP_RINC, 16'hc123);
    rx_page = {16'h3e96, 16'h4a1b, 16'h5a5e};
    pulse(rx_page_valid);
    rdc(OFS_LP1, 16'hb7e4);
    wr(OFS_LP0, 16'h0000);
    host.frame(32, OP_ADDR, port_addr, MMD_ADDR, OFS_LP0, r);
    rdn(OP_RINC, 16'h5a41);
    rdn(OP_RINC, 16'h4a1b);
    rdn(OP_RINC, 16'h3e96);
    $display("Test partner page done");

    host.frame(32, OP_ADDR, port_addr, MMD_ADDR, OFS_NP1, r);
    host.frame(32, OP_WRITE, 5'h06, MMD_ADDR, 16'h1111, r);
    host.frame(32, OP_WRITE, port_addr, 5'h01, 16'h2222, r);
    host.frame(31, OP_WRITE, port_addr, MMD_ADDR, 16'h3333, r);
    host.frame(32, 2'h3, 5'h06, MMD_ADDR, 16'h0000, r);
    check(r[15:0], 16'hffff);
    rdc(OFS_NP1, 16'ha5c3);
    wr(16'h0020, 16'hffff);
    rdc(16'h0020, 16'h0000);
    $display("Test refused frames done");
    end_of_test();
  end
endmodule // tb_anpr_page_regs
